// >>> pkg/ssrb_params.svh
// register map, field positions, reset values and bus constants of the status register bank
`ifndef SSRB_PARAMS_SVH
`define SSRB_PARAMS_SVH

`define SSRB_ADDR_W 16
`define SSRB_OFF_CHIP_IDENTITY 16'h0000
`define SSRB_OFF_FRAME_COUNTER 16'h0004
`define SSRB_OFF_CYCLE_COUNTER 16'h0008
`define SSRB_OFF_HOST_BUS_WIDTH 16'h0188
`define SSRB_OFF_TOUCH_TRACK_FIRST 16'h7000
`define SSRB_OFF_TOUCH_TRACK_SECOND 16'h7004
`define SSRB_OFF_TOUCH_CTRL 16'h7100
`define SSRB_ID_DEFAULT 8'h5A
`define SSRB_WIDTH_RESET 3'h0
`define SSRB_WIDTH_BIT_DUMMY 2
`define SSRB_WIDTH_FIELD_HI 1
`define SSRB_WIDTH_FIELD_LO 0
`define SSRB_TRACK_VALUE_HI 31
`define SSRB_TRACK_VALUE_LO 16
`define SSRB_TRACK_TAG_HI 7
`define SSRB_TRACK_TAG_LO 0
`define SSRB_RESP_OKAY 2'h0
`define SSRB_RESP_SLVERR 2'h2

`endif

// >>> pkg/ssrb_pkg.sv
// types shared by the status register bank modules
package ssrb_pkg;
	typedef enum logic [1:0] {
		SSRB_LINES_ONE = 2'b00,
		SSRB_LINES_TWO = 2'b01,
		SSRB_LINES_FOUR = 2'b10,
		SSRB_LINES_BAD = 2'b11
	} ssrb_lines_e;

	typedef enum logic [1:0] {
		SSRB_BUS_IDLE = 2'b00,
		SSRB_BUS_RESP = 2'b01
	} ssrb_bus_e;

	typedef struct packed {
		logic [31:0] value;
	} ssrb_cnt_s;
endpackage : ssrb_pkg

// >>> pkg/ssrb_cnt_if.sv
// counter control and value carried between the bank and its counters
`timescale 1ns/1ps
interface ssrb_cnt_if;
	logic step;
	logic [31:0] value;
	modport owner(input step, output value);
	modport user(output step, input value);
endinterface : ssrb_cnt_if

// >>> core/ssrb_counter.sv
// wrapping 32-bit event counter
`timescale 1ns/1ps
module ssrb_counter (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// step in, value out
	ssrb_cnt_if.owner cnt
);
	ssrb_pkg::ssrb_cnt_s state_reg;
	ssrb_pkg::ssrb_cnt_s state_next;

	always_comb begin
		state_next = state_reg;
		if (cnt.step) begin
			state_next.value = state_reg.value + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign cnt.value = state_reg.value;

	counter_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cnt.step && (state_reg.value == 32'hFFFF_FFFF) |=> state_reg.value == 32'h0000_0000)
		else $error("counter did not wrap to zero");
	counter_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!cnt.step |=> $stable(state_reg.value))
		else $error("counter moved without a step");
endmodule : ssrb_counter

// >>> core/ssrb_bank.sv
// status register bank with an axi4-lite slave
`timescale 1ns/1ps
`include "ssrb_params.svh"
module ssrb_bank #(
	parameter logic [7:0] CHIP_ID = `SSRB_ID_DEFAULT // arbitrary value
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// axi4-lite write address and data
	input wire logic [15:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	// axi4-lite write response
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// axi4-lite read address
	input wire logic [15:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	// axi4-lite read data
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// display and touch engine inputs
	input wire logic i_frame_done,
	input wire logic [15:0] i_track0_value,
	input wire logic [7:0] i_track0_tag,
	input wire logic i_track0_load,
	input wire logic [15:0] i_track1_value,
	input wire logic [7:0] i_track1_tag,
	input wire logic i_track1_load,
	// host serial interface and touch settings
	output logic [1:0] o_host_lines,
	output logic o_host_dummy,
	output logic o_multi_touch
);
	typedef struct packed {
		logic aw_have;
		logic [15:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		ssrb_pkg::ssrb_bus_e wr_st;
		logic [1:0] bresp;
		ssrb_pkg::ssrb_bus_e rd_st;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] width;
		logic multi;
		logic [31:0] track0;
		logic [31:0] track1;
	} ssrb_bank_s;

	ssrb_bank_s state_reg;
	ssrb_bank_s state_next;

	ssrb_cnt_if cyc_if();
	ssrb_cnt_if frm_if();

	assign cyc_if.step = 1'b1;
	assign frm_if.step = i_frame_done;

	ssrb_counter u_cycle (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.cnt(cyc_if.owner)
	);

	ssrb_counter u_frame (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.cnt(frm_if.owner)
	);

	// word decode for reads; miss flags slverr
	function automatic logic [32:0] read_word(input logic [15:0] addr, input ssrb_bank_s s,
		input logic [31:0] cyc, input logic [31:0] frm);
		logic [15:0] a;
		a = {addr[15:2], 2'b00};
		if (a == `SSRB_OFF_CHIP_IDENTITY) begin
			read_word = {1'b0, 24'h00_0000, CHIP_ID};
		end else if (a == `SSRB_OFF_FRAME_COUNTER) begin
			read_word = {1'b0, frm};
		end else if (a == `SSRB_OFF_CYCLE_COUNTER) begin
			read_word = {1'b0, cyc};
		end else if (a == `SSRB_OFF_HOST_BUS_WIDTH) begin
			read_word = {1'b0, 29'h0000_0000, s.width};
		end else if (a == `SSRB_OFF_TOUCH_TRACK_FIRST) begin
			read_word = {1'b0, s.track0};
		end else if (a == `SSRB_OFF_TOUCH_TRACK_SECOND) begin
			read_word = {1'b0, s.track1};
		end else if (a == `SSRB_OFF_TOUCH_CTRL) begin
			read_word = {1'b0, 31'h0000_0000, s.multi};
		end else begin
			read_word = {1'b1, 32'h0000_0000};
		end
	endfunction : read_word

	// tracker word: value high, tag low, reserved middle zero
	function automatic logic [31:0] track_word(input logic [15:0] value, input logic [7:0] tag);
		track_word = {value, 8'h00, tag};
	endfunction : track_word

	logic [32:0] rd_word;
	assign rd_word = read_word(i_araddr, state_reg, cyc_if.value, frm_if.value);

	always_comb begin
		logic [15:0] wa;
		wa = '0;
		state_next = state_reg;
		if (!state_reg.aw_have && i_awvalid) begin
			state_next.aw_have = 1'b1;
			state_next.aw_addr = i_awaddr;
		end
		if (!state_reg.w_have && i_wvalid) begin
			state_next.w_have = 1'b1;
			state_next.w_data = i_wdata;
			state_next.w_strb = i_wstrb;
		end
		case (state_reg.wr_st)
			ssrb_pkg::SSRB_BUS_IDLE: begin
				if (state_reg.aw_have && state_reg.w_have) begin
					wa = {state_reg.aw_addr[15:2], 2'b00};
					state_next.aw_have = 1'b0;
					state_next.w_have = 1'b0;
					state_next.wr_st = ssrb_pkg::SSRB_BUS_RESP;
					state_next.bresp = `SSRB_RESP_OKAY;
					if (wa == `SSRB_OFF_HOST_BUS_WIDTH) begin
						if (state_reg.w_strb[0]) begin
							state_next.width = state_reg.w_data[2:0];
						end
					end else if (wa == `SSRB_OFF_TOUCH_CTRL) begin
						if (state_reg.w_strb[0]) begin
							state_next.multi = state_reg.w_data[0];
						end
					end else if (read_word(state_reg.aw_addr, state_reg, 32'h0, 32'h0) == 33'h1_0000_0000) begin
						state_next.bresp = `SSRB_RESP_SLVERR;
					end
				end
			end
			ssrb_pkg::SSRB_BUS_RESP: begin
				if (i_bready) begin
					state_next.wr_st = ssrb_pkg::SSRB_BUS_IDLE;
				end
			end
			default: begin
				state_next.wr_st = ssrb_pkg::SSRB_BUS_IDLE;
			end
		endcase
		case (state_reg.rd_st)
			ssrb_pkg::SSRB_BUS_IDLE: begin
				if (i_arvalid) begin
					state_next.rd_st = ssrb_pkg::SSRB_BUS_RESP;
					state_next.rdata = rd_word[31:0];
					state_next.rresp = rd_word[32] ? `SSRB_RESP_SLVERR : `SSRB_RESP_OKAY;
				end
			end
			ssrb_pkg::SSRB_BUS_RESP: begin
				if (i_rready) begin
					state_next.rd_st = ssrb_pkg::SSRB_BUS_IDLE;
				end
			end
			default: begin
				state_next.rd_st = ssrb_pkg::SSRB_BUS_IDLE;
			end
		endcase
		if (i_track0_load) begin
			state_next.track0 = track_word(i_track0_value, i_track0_tag);
		end
		// second point only in extended mode
		if (i_track1_load && state_reg.multi) begin
			state_next.track1 = track_word(i_track1_value, i_track1_tag);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= '0;
			state_reg.width <= `SSRB_WIDTH_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_awready = !state_reg.aw_have;
	assign o_wready = !state_reg.w_have;
	assign o_bvalid = (state_reg.wr_st == ssrb_pkg::SSRB_BUS_RESP);
	assign o_bresp = state_reg.bresp;
	assign o_arready = (state_reg.rd_st == ssrb_pkg::SSRB_BUS_IDLE);
	assign o_rvalid = (state_reg.rd_st == ssrb_pkg::SSRB_BUS_RESP);
	assign o_rdata = state_reg.rdata;
	assign o_rresp = state_reg.rresp;
	assign o_host_lines = state_reg.width[`SSRB_WIDTH_FIELD_HI:`SSRB_WIDTH_FIELD_LO];
	assign o_host_dummy = state_reg.width[`SSRB_WIDTH_BIT_DUMMY];
	assign o_multi_touch = state_reg.multi;

	cycle_step_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		1'b1 |=> cyc_if.value == $past(cyc_if.value) + 32'h0000_0001)
		else $error("cycle counter did not step");
	frame_step_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_frame_done |=> frm_if.value == $past(frm_if.value) + 32'h0000_0001)
		else $error("frame counter missed a frame");
	frame_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_frame_done && frm_if.value == 32'hFFFF_FFFF |=> frm_if.value == 32'h0000_0000)
		else $error("frame counter did not wrap");
	id_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_arready && i_arvalid && i_araddr[15:2] == 14'h0000 |=> o_rvalid && o_rdata == {24'h00_0000, CHIP_ID})
		else $error("identity read wrong");
	dummy_out_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!(state_reg.wr_st == ssrb_pkg::SSRB_BUS_IDLE && state_reg.aw_have && state_reg.w_have)
		|=> $stable(o_host_dummy) && $stable(o_host_lines))
		else $error("width outputs moved without a write");
	width_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_reg.wr_st == ssrb_pkg::SSRB_BUS_IDLE && state_reg.aw_have && state_reg.w_have
		&& state_reg.aw_addr[15:2] == 14'h0062 && state_reg.w_strb[0]
		|=> o_host_lines == $past(state_reg.w_data[1:0]) && o_host_dummy == $past(state_reg.w_data[2])
		&& o_bvalid)
		else $error("width write not applied");
	track_map_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_track0_load |=> state_reg.track0 == {$past(i_track0_value), 8'h00, $past(i_track0_tag)})
		else $error("first tracker not loaded");
	track_rsv_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_reg.track0[15:8] == 8'h00 && state_reg.track1[15:8] == 8'h00)
		else $error("tracker reserved bits set");
	second_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!o_multi_touch && !i_rst |=> $stable(state_reg.track1))
		else $error("second tracker moved outside extended mode");
	ro_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_reg.wr_st == ssrb_pkg::SSRB_BUS_IDLE && state_reg.aw_have && state_reg.w_have
		&& state_reg.aw_addr[15:2] == 14'h0000 |=> $stable(o_host_lines) && $stable(o_multi_touch))
		else $error("read-only write had an effect");
	track_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_arready && i_arvalid && i_araddr[15:2] == 14'h1C00 |=> o_rdata == $past(state_reg.track0))
		else $error("first tracker read wrong");
endmodule : ssrb_bank

// >>> verif/ssrb_engine_model.sv
// display and touch engine model driving frame pulses and tracker loads
`timescale 1ns/1ps
module ssrb_engine_model (
	// clock
	input wire logic i_ref_clk,
	// engine outputs
	output logic o_frame_done,
	output logic [1:0] o_load,
	output logic [1:0][15:0] o_value,
	output logic [1:0][7:0] o_tag
);
	initial begin
		o_frame_done = 1'b0;
		o_load = 2'b00;
		o_value = '1;
		o_tag = '1;
	end
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge i_ref_clk);
			o_frame_done <= 1'b1;
			@(posedge i_ref_clk);
			o_frame_done <= 1'b0;
		end
	endtask : frames
	// lines go to the inverse once the load pulse ends
	task track(input int s, input logic [15:0] v, input logic [7:0] t);
		@(posedge i_ref_clk);
		o_value[s] <= v;
		o_tag[s] <= t;
		o_load[s] <= 1'b1;
		@(posedge i_ref_clk);
		o_load[s] <= 1'b0;
		o_value[s] <= ~v;
		o_tag[s] <= ~t;
	endtask : track
endmodule : ssrb_engine_model

// >>> verif/system_status_register_bank_tb_top.sv
// self-checking testbench of the status register bank
`timescale 1ns/1ps
`include "ssrb_params.svh"
module system_status_register_bank_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, fd, lines_dummy, multi;
	logic [1:0] bresp, rresp, lines, ld;
	logic [1:0][15:0] val;
	logic [1:0][7:0] tg;
	int fail_count = 0, checked = 0, cyc = 0, rel_cyc = 0;
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	ssrb_engine_model u_eng (.i_ref_clk(clk), .o_frame_done(fd), .o_load(ld), .o_value(val), .o_tag(tg));
	ssrb_bank u_dut (.i_ref_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_frame_done(fd),
		.i_track0_value(val[0]), .i_track0_tag(tg[0]), .i_track0_load(ld[0]), .i_track1_value(val[1]),
		.i_track1_tag(tg[1]), .i_track1_load(ld[1]), .o_host_lines(lines), .o_host_dummy(lines_dummy),
		.o_multi_touch(multi));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (1) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r, output int k);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (1) begin
			@(posedge clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				k = cyc;
			end
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic rdc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		int k;
		rd(a, d, r, k);
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask : rdc
	task automatic t_reset;
		chk({28'h0, lines, lines_dummy, multi}, 32'h0);
		rdc(`SSRB_OFF_CHIP_IDENTITY, {24'h0, `SSRB_ID_DEFAULT}, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_FRAME_COUNTER, 32'h0, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_HOST_BUS_WIDTH, 32'h0, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_TOUCH_TRACK_FIRST, 32'h0, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_TOUCH_TRACK_SECOND, 32'h0, `SSRB_RESP_OKAY);
	endtask : t_reset
	task automatic t_cycles;
		logic [31:0] d1, d2;
		logic [1:0] r;
		int k1, k2;
		rd(`SSRB_OFF_CYCLE_COUNTER, d1, r, k1);
		chk(d1, k1 - rel_cyc - 1);
		repeat (7) @(posedge clk);
		rd(`SSRB_OFF_CYCLE_COUNTER, d2, r, k2);
		chk(d2 - d1, k2 - k1);
	endtask : t_cycles
	task automatic t_width;
		for (int i = 0; i < 8; i++) begin
			// width code 11 is never used by the host
			if (i[1:0] == 2'b11) continue;
			wr(`SSRB_OFF_HOST_BUS_WIDTH, 32'hFFFF_FFF8 | i, `SSRB_RESP_OKAY);
			rdc(`SSRB_OFF_HOST_BUS_WIDTH, i, `SSRB_RESP_OKAY);
			chk({29'h0, lines_dummy, lines}, i);
		end
		wr(`SSRB_OFF_HOST_BUS_WIDTH, 32'h0000_0000, `SSRB_RESP_OKAY);
	endtask : t_width
	task automatic t_ro;
		u_eng.frames(5);
		rdc(`SSRB_OFF_FRAME_COUNTER, 32'h0000_0005, `SSRB_RESP_OKAY);
		wr(`SSRB_OFF_CHIP_IDENTITY, 32'h0000_0000, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_CHIP_IDENTITY, {24'h0, `SSRB_ID_DEFAULT}, `SSRB_RESP_OKAY);
		wr(`SSRB_OFF_FRAME_COUNTER, 32'h0000_0000, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_FRAME_COUNTER, 32'h0000_0005, `SSRB_RESP_OKAY);
	endtask : t_ro
	task automatic t_track;
		u_eng.track(0, 16'hA5C3, 8'h3C);
		rdc(`SSRB_OFF_TOUCH_TRACK_FIRST, 32'hA5C3_003C, `SSRB_RESP_OKAY);
		wr(`SSRB_OFF_TOUCH_TRACK_FIRST, 32'hFFFF_FFFF, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_TOUCH_TRACK_FIRST, 32'hA5C3_003C, `SSRB_RESP_OKAY);
		u_eng.track(1, 16'h5A5A, 8'h77);
		rdc(`SSRB_OFF_TOUCH_TRACK_SECOND, 32'h0000_0000, `SSRB_RESP_OKAY);
		wr(`SSRB_OFF_TOUCH_CTRL, 32'h0000_0001, `SSRB_RESP_OKAY);
		chk({31'h0, multi}, 32'h0000_0001);
		u_eng.track(1, 16'h1234, 8'h81);
		rdc(`SSRB_OFF_TOUCH_TRACK_SECOND, 32'h1234_0081, `SSRB_RESP_OKAY);
	endtask : t_track
	task automatic t_unmapped;
		rdc(16'h0100, 32'h0, `SSRB_RESP_SLVERR);
		rdc(16'h7008, 32'h0, `SSRB_RESP_SLVERR);
		wr(16'h7008, 32'hFFFF_FFFF, `SSRB_RESP_SLVERR);
	endtask : t_unmapped
	task automatic t_rerst;
		logic [31:0] d;
		logic [1:0] r;
		int k;
		wr(`SSRB_OFF_HOST_BUS_WIDTH, 32'h0000_0006, `SSRB_RESP_OKAY);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rel_cyc = cyc;
		chk({28'h0, lines, lines_dummy, multi}, 32'h0);
		rdc(`SSRB_OFF_FRAME_COUNTER, 32'h0, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_TOUCH_TRACK_FIRST, 32'h0, `SSRB_RESP_OKAY);
		rdc(`SSRB_OFF_TOUCH_TRACK_SECOND, 32'h0, `SSRB_RESP_OKAY);
		rd(`SSRB_OFF_CYCLE_COUNTER, d, r, k);
		chk(d, k - rel_cyc - 1);
	endtask : t_rerst
	task automatic final_report;
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rel_cyc = cyc;
		t_reset();
		t_cycles();
		t_width();
		t_ro();
		t_track();
		t_rerst();
		t_unmapped();
		final_report();
	end
	initial begin
		#(40 * 5000);
		fail_count++;
		final_report();
	end
endmodule : system_status_register_bank_tb_top
